// *** electrode_off_and_wct_control.sv ***
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps

// Summary of operation
// - each averaging amp selects one of eight inputs
// - each averaging amp has own power bit
// - terminal averages the powered amplifiers
// - amplifier inputs chopped at eight kilohertz
// - eight-channel variant routes averages into channels 5-7
// - option buffers terminal onto drive pin
// - separate positive and negative detect enables
// - excitation disableable while comparators stay on
// - bit selects resistor or current excitation
// - dc pulls opposite sides, swap per channel
// - two-bit field sets excitation current
// - three-bit threshold drives four-bit dac
// - status registers appended to every frame
// - bit powers down the off comparators
// - ac toggles pulls at half or quarter rate
module electrode_off_and_wct_control #(
  parameter int NUM_CH      = 8,
  parameter bit EIGHT_CH_VARIANT = 1'b1
) (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // conversion timing and comparators
  input  wire logic                      data_ready,
  input  wire logic [NUM_CH-1:0]         pos_comp_off,
  input  wire logic [NUM_CH-1:0]         neg_comp_off,
  // averaging amplifier controls
  output elec_pkg::avg_route_t           avg_route,
  output logic                           chop_clk,
  output logic                           aug_lead_route,
  output logic                           ref_to_drive_pin,
  // off-detect analog controls
  output elec_pkg::pull_drive_t          pull_drive,
  output logic                           current_mode,
  output logic [1:0]                     excite_current_level,
  output logic [3:0]                     threshold_dac,
  output logic                           comparator_enable,
  // status into the output frame
  output logic [2*NUM_CH-1:0]            frame_status,
  output logic                           irq
);

  if (NUM_CH != 8) begin : g_num_ch_check
    $error("NUM_CH must be 8");
  end

  // ----------
  // registers
  // ----------
  logic [8:0]        avg_sel_ff;
  logic [4:0]        avg_ctl_ff;
  logic [NUM_CH-1:0] pos_off_detect_enables_ff;
  logic [NUM_CH-1:0] neg_off_detect_enables_ff;
  logic [7:0]        off_detect_config_ff;
  logic [NUM_CH-1:0] pull_polarity_swap_ff;
  logic [1:0]        config_reg_four_ff;
  logic [NUM_CH-1:0] pos_off_status_ff;
  logic [NUM_CH-1:0] neg_off_status_ff;
  logic [1:0]        irq_status_ff;
  logic [1:0]        irq_mask_ff;

  // write a 32-bit word through byte strobes onto an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // ----------
  // axi write channel
  // ----------
  logic [7:0]  awaddr_ff;
  logic        aw_have_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_have_ff;
  logic        wr_go;
  logic        wr_hit;

  assign wr_go  = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign wr_hit = (awaddr_ff <= elec_pkg::ADDR_IRQ_MASK) && (awaddr_ff[1:0] == 2'h0);

  // address and data taken in either order, held until the write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff    <= 1'b0;
      w_have_ff     <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_ff   <= 1'b0;
        w_have_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? elec_pkg::RESP_OKAY : elec_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg_sel_ff                <= 9'h000;
      avg_ctl_ff                <= 5'h00;
      pos_off_detect_enables_ff <= 8'h00;
      neg_off_detect_enables_ff <= 8'h00;
      off_detect_config_ff      <= 8'h00;
      pull_polarity_swap_ff     <= 8'h00;
      config_reg_four_ff        <= 2'h0;
      irq_mask_ff               <= 2'h0;
    end else if (wr_go) begin
      case (awaddr_ff)
        elec_pkg::ADDR_AVG_SELECT:
          avg_sel_ff <= 9'(merge({23'h0, avg_sel_ff}, wdata_ff, wstrb_ff));
        elec_pkg::ADDR_AVG_CONTROL:
          avg_ctl_ff <= 5'(merge({27'h0, avg_ctl_ff}, wdata_ff, wstrb_ff));
        elec_pkg::ADDR_POS_ENABLES:
          pos_off_detect_enables_ff <= 8'(merge({24'h0, pos_off_detect_enables_ff},
                                                wdata_ff, wstrb_ff));
        elec_pkg::ADDR_NEG_ENABLES:
          neg_off_detect_enables_ff <= 8'(merge({24'h0, neg_off_detect_enables_ff},
                                                wdata_ff, wstrb_ff));
        elec_pkg::ADDR_OFF_CONFIG:
          off_detect_config_ff <= 8'(merge({24'h0, off_detect_config_ff}, wdata_ff, wstrb_ff));
        elec_pkg::ADDR_SWAP:
          pull_polarity_swap_ff <= 8'(merge({24'h0, pull_polarity_swap_ff},
                                            wdata_ff, wstrb_ff));
        elec_pkg::ADDR_CONFIG_FOUR:
          config_reg_four_ff <= 2'(merge({30'h0, config_reg_four_ff}, wdata_ff, wstrb_ff));
        elec_pkg::ADDR_IRQ_MASK:
          irq_mask_ff <= 2'(merge({30'h0, irq_mask_ff}, wdata_ff, wstrb_ff));
        default: ;
      endcase
    end
  end

  // ----------
  // axi read channel
  // ----------
  logic        rd_take;
  logic        rd_irq_clr;
  logic [31:0] rd_word;

  assign rd_take = s_axi_arvalid && s_axi_arready;

  // read mux over live register state
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      elec_pkg::ADDR_AVG_SELECT:  rd_word = {23'h0, avg_sel_ff};
      elec_pkg::ADDR_AVG_CONTROL: rd_word = {27'h0, avg_ctl_ff};
      elec_pkg::ADDR_POS_ENABLES: rd_word = {24'h0, pos_off_detect_enables_ff};
      elec_pkg::ADDR_NEG_ENABLES: rd_word = {24'h0, neg_off_detect_enables_ff};
      elec_pkg::ADDR_OFF_CONFIG:  rd_word = {24'h0, off_detect_config_ff};
      elec_pkg::ADDR_SWAP:        rd_word = {24'h0, pull_polarity_swap_ff};
      elec_pkg::ADDR_CONFIG_FOUR: rd_word = {30'h0, config_reg_four_ff};
      elec_pkg::ADDR_POS_STATUS:  rd_word = {24'h0, pos_off_status_ff};
      elec_pkg::ADDR_NEG_STATUS:  rd_word = {24'h0, neg_off_status_ff};
      elec_pkg::ADDR_IRQ_STATUS:  rd_word = {30'h0, irq_status_ff};
      elec_pkg::ADDR_IRQ_MASK:    rd_word = {30'h0, irq_mask_ff};
      default:                    rd_word = 32'h0000_0000;
    endcase
  end

  assign rd_irq_clr = rd_take && (s_axi_araddr == elec_pkg::ADDR_IRQ_STATUS);

  // one read at a time; arready only while no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= ((s_axi_araddr <= elec_pkg::ADDR_IRQ_MASK) &&
                         (s_axi_araddr[1:0] == 2'h0)) ? elec_pkg::RESP_OKAY
                                                      : elec_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------
  // averaging amplifiers
  // ----------
  // selections and power bits straight out; the analog summing network
  // averages whichever amps are on, so one, two or three give levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      avg_route        <= '0;
      aug_lead_route   <= 1'b0;
      ref_to_drive_pin <= 1'b0;
    end else begin
      avg_route.sel_a  <= avg_sel_ff[2:0];
      avg_route.sel_b  <= avg_sel_ff[5:3];
      avg_route.sel_c  <= avg_sel_ff[8:6];
      avg_route.pwr    <= avg_ctl_ff[elec_pkg::CTL_PWR_C:elec_pkg::CTL_PWR_A];
      aug_lead_route   <= EIGHT_CH_VARIANT & avg_ctl_ff[elec_pkg::CTL_AUG_LEADS];
      ref_to_drive_pin <= avg_ctl_ff[elec_pkg::CTL_REF_DRIVE];
    end
  end

  // chopper divider; runs only while some amp is powered to save toggling
  logic [$clog2(elec_pkg::CHOP_HALF)-1:0] chop_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || avg_ctl_ff[2:0] == 3'h0) begin
      chop_cnt_ff <= '0;
      chop_clk    <= 1'b0;
    end else if (chop_cnt_ff == ($clog2(elec_pkg::CHOP_HALF))'(elec_pkg::CHOP_HALF - 1)) begin
      chop_cnt_ff <= '0;
      chop_clk    <= ~chop_clk;
    end else begin
      chop_cnt_ff <= chop_cnt_ff + 1'b1;
    end
  end

  // ----------
  // excitation
  // ----------
  logic [1:0]               freq_sel;
  logic [1:0]               ac_phase_ff;
  logic                     ac_level;
  logic                     excite_on;
  elec_pkg::excite_mode_t   mode;

  assign freq_sel  = off_detect_config_ff[elec_pkg::CFG_FREQ_LO +: 2];
  assign excite_on = !config_reg_four_ff[elec_pkg::CF4_EXC_OFF];
  assign mode      = !excite_on ? elec_pkg::EXC_IDLE :
                     (freq_sel == elec_pkg::FREQ_DC) ? elec_pkg::EXC_DC : elec_pkg::EXC_AC;
  // half rate flips every sample, quarter rate every second sample
  assign ac_level  = (freq_sel == elec_pkg::FREQ_QUART) ? ac_phase_ff[1] : ac_phase_ff[0];

  // ac phase advanced by the data-rate strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_phase_ff <= 2'h0;
    end else if (data_ready) begin
      ac_phase_ff <= ac_phase_ff + 2'h1;
    end
  end

  // pull pattern: positive side up unless swapped; ac flips both sides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull_drive <= '0;
    end else begin
      case (mode)
        elec_pkg::EXC_DC: begin
          pull_drive.pos_pull_up <= pos_off_detect_enables_ff & ~pull_polarity_swap_ff;
          pull_drive.pos_pull_dn <= pos_off_detect_enables_ff & pull_polarity_swap_ff;
          pull_drive.neg_pull_up <= neg_off_detect_enables_ff & pull_polarity_swap_ff;
          pull_drive.neg_pull_dn <= neg_off_detect_enables_ff & ~pull_polarity_swap_ff;
        end
        elec_pkg::EXC_AC: begin
          pull_drive.pos_pull_up <= ac_level ? pos_off_detect_enables_ff : 8'h00;
          pull_drive.pos_pull_dn <= ac_level ? 8'h00 : pos_off_detect_enables_ff;
          pull_drive.neg_pull_up <= ac_level ? 8'h00 : neg_off_detect_enables_ff;
          pull_drive.neg_pull_dn <= ac_level ? neg_off_detect_enables_ff : 8'h00;
        end
        default: pull_drive <= '0;
      endcase
    end
  end

  // current settings and comparator controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_mode         <= 1'b0;
      excite_current_level <= 2'h0;
      threshold_dac        <= 4'h0;
      comparator_enable    <= 1'b0;
    end else begin
      current_mode         <= off_detect_config_ff[elec_pkg::CFG_SRC_SEL];
      excite_current_level <= off_detect_config_ff[elec_pkg::CFG_CUR_LO +: 2];
      // three-bit code lands on the odd dac levels; lsb held high
      threshold_dac        <= {off_detect_config_ff[elec_pkg::CFG_THR_LO +: 3], 1'b1};
      comparator_enable    <= !config_reg_four_ff[elec_pkg::CF4_CMP_PD];
    end
  end

  // ----------
  // comparator status, frame copy and interrupt
  // ----------
  logic [NUM_CH-1:0] pos_live;
  logic [NUM_CH-1:0] neg_live;
  logic [1:0]        irq_event;

  assign pos_live  = comparator_enable ? (pos_comp_off & pos_off_detect_enables_ff) : '0;
  assign neg_live  = comparator_enable ? (neg_comp_off & neg_off_detect_enables_ff) : '0;
  assign irq_event = {|(neg_live & ~neg_off_status_ff), |(pos_live & ~pos_off_status_ff)};

  // live status, bit n is channel n+1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_off_status_ff <= 8'h00;
      neg_off_status_ff <= 8'h00;
    end else begin
      pos_off_status_ff <= pos_live;
      neg_off_status_ff <= neg_live;
    end
  end

  // both status bytes latched into each frame at the data strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_status <= '0;
    end else if (data_ready) begin
      frame_status <= {pos_off_status_ff, neg_off_status_ff};
    end
  end

  // sticky events: a new event on the clearing read is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= 2'h0;
      irq           <= 1'b0;
    end else begin
      irq_status_ff <= (rd_irq_clr ? 2'h0 : irq_status_ff) | irq_event;
      irq           <= |(((rd_irq_clr ? 2'h0 : irq_status_ff) | irq_event) & irq_mask_ff);
    end
  end

endmodule : electrode_off_and_wct_control

// *** elec_pkg.sv ***
package elec_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_AVG_SELECT  = 8'h00;
  localparam logic [7:0] ADDR_AVG_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_POS_ENABLES = 8'h08;
  localparam logic [7:0] ADDR_NEG_ENABLES = 8'h0C;
  localparam logic [7:0] ADDR_OFF_CONFIG  = 8'h10;
  localparam logic [7:0] ADDR_SWAP        = 8'h14;
  localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h18;
  localparam logic [7:0] ADDR_POS_STATUS  = 8'h1C;
  localparam logic [7:0] ADDR_NEG_STATUS  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // avg_select: [2:0] amp a, [5:3] amp b, [8:6] amp c
  localparam int SEL_W         = 3;
  // avg_control
  localparam int CTL_PWR_A     = 0;
  localparam int CTL_PWR_B     = 1;
  localparam int CTL_PWR_C     = 2;
  localparam int CTL_AUG_LEADS = 3;
  localparam int CTL_REF_DRIVE = 4;
  // off_detect_config
  localparam int CFG_FREQ_LO   = 0;  // ac_excite_freq_select [1:0]
  localparam int CFG_CUR_LO    = 2;  // excite_current_level [1:0]
  localparam int CFG_SRC_SEL   = 4;  // excite_source_select
  localparam int CFG_THR_LO    = 5;  // comparator_threshold [2:0]
  // config_reg_four
  localparam int CF4_CMP_PD    = 0;  // comparator_powerdown
  localparam int CF4_EXC_OFF   = 1;  // excitation disable
  // irq bits
  localparam int IRQ_POS       = 0;
  localparam int IRQ_NEG       = 1;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  FREQ_DC     = 2'h0;
  localparam logic [1:0]  FREQ_HALF   = 2'h1;
  localparam logic [1:0]  FREQ_QUART  = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int CHOP_KHZ    = 8;
  localparam int CHOP_HALF   = (CLK_MHZ * 1000) / (2 * CHOP_KHZ);

  typedef enum logic [1:0] {
    EXC_IDLE,
    EXC_DC,
    EXC_AC
  } excite_mode_t;

  // excitation drive for the pair of inputs of all eight channels, one bit per channel
  typedef struct packed {
    logic [7:0] pos_pull_up;
    logic [7:0] pos_pull_dn;
    logic [7:0] neg_pull_up;
    logic [7:0] neg_pull_dn;
  } pull_drive_t;

  // routing of the averaging amplifiers
  typedef struct packed {
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic [2:0] sel_c;
    logic [2:0] pwr;
  } avg_route_t;

endpackage : elec_pkg

// *** electrode_off_assertions.sv ***
`timescale 1ns/10ps
// ----------
// port-level checker
// ----------
module elec_off_checker #(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // bus answers
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // analog controls and frame
  input wire logic                  data_ready,
  input wire elec_pkg::avg_route_t  avg_route,
  input wire logic                  chop_clk,
  input wire elec_pkg::pull_drive_t pull_drive,
  input wire logic [3:0]            threshold_dac,
  input wire logic                  comparator_enable,
  input wire logic [2*NUM_CH-1:0]   frame_status
);
  localparam int HALF_M1 = elec_pkg::CHOP_HALF - 1;
  logic [15:0] run_ff;
  logic        prev_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since chop_clk last moved; saturates so a long idle cannot wrap
  always_ff @(posedge aclk) begin
    prev_ff <= chop_clk;
    if (!aresetn || chop_clk != prev_ff) run_ff <= 16'h0000;
    else if (run_ff != 16'hFFFF) run_ff <= run_ff + 16'h0001;
  end

  property p_resp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_resp_hold: assert property (p_resp_hold) else $error("write response dropped");
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
  // power changes may cut a phase short, so only steady phases are timed
  property p_chop_half;
    (chop_clk != prev_ff) && !chop_clk && avg_route.pwr != 3'h0
      && $past(avg_route.pwr) != 3'h0 |-> run_ff == HALF_M1;
  endproperty
  a_chop_half: assert property (p_chop_half) else $error("chop half period wrong");
  property p_chop_idle;
    avg_route.pwr == 3'h0 ##1 avg_route.pwr == 3'h0 |-> !chop_clk;
  endproperty
  a_chop_idle: assert property (p_chop_idle) else $error("chop runs unpowered");
  property p_thr_lsb;
    threshold_dac != 4'h0 |-> threshold_dac[0];
  endproperty
  a_thr_lsb: assert property (p_thr_lsb) else $error("threshold low bit clear");
  property p_frame_edge;
    $changed(frame_status) |-> $past(data_ready);
  endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("frame moved off strobe");
  property p_comp_pd;
    !comparator_enable [*3] ##0 data_ready |=> frame_status == '0;
  endproperty
  a_comp_pd: assert property (p_comp_pd) else $error("status while powered down");
  property p_pull_excl;
    (pull_drive.pos_pull_up & pull_drive.pos_pull_dn) == 8'h00
      && (pull_drive.neg_pull_up & pull_drive.neg_pull_dn) == 8'h00;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("input pulled both ways");
endmodule : elec_off_checker

bind electrode_off_and_wct_control elec_off_checker #(.NUM_CH(NUM_CH)) elec_off_checker_i (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .data_ready, .avg_route, .chop_clk, .pull_drive,
  .threshold_dac, .comparator_enable, .frame_status
);

// *** host_frame_model.sv ***
`timescale 1ns/10ps
// ----------
// host side: strobes one sample and reads the status pair back
// ----------
module host_frame_model (
  // clock
  input wire logic        aclk,
  // frame interface
  input wire logic [15:0] frame_status,
  output logic            data_ready
);
  initial data_ready = 1'b0;

  // one-cycle strobe; the host alone decides which side is off from these bits
  task automatic take_frame(output logic [15:0] f);
    @(posedge aclk);
    data_ready <= 1'b1;
    @(posedge aclk);
    data_ready <= 1'b0;
    repeat (2) @(posedge aclk);
    f = frame_status;
  endtask : take_frame
endmodule : host_frame_model

// *** electrode_off_and_wct_control_bench.sv ***
`timescale 1ns/10ps
// ----------
// bench
// ----------
module electrode_off_and_wct_control_bench;
  logic                  aclk, aresetn, data_ready, irq, chop_clk, current_mode;
  logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic                  s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_arready, s_axi_rvalid, aug_lead_route, ref_to_drive_pin;
  logic                  comparator_enable;
  logic [7:0]            s_axi_awaddr, s_axi_araddr, pos_comp_off, neg_comp_off;
  logic [31:0]           s_axi_wdata, s_axi_rdata, d;
  logic [3:0]            s_axi_wstrb, threshold_dac;
  logic [1:0]            s_axi_bresp, s_axi_rresp, excite_current_level, r;
  logic [15:0]           frame_status, fr;
  elec_pkg::avg_route_t  avg_route;
  elec_pkg::pull_drive_t pull_drive, p0;
  int                    mismatches, samples_checked, n;

  electrode_off_and_wct_control electrode_off_and_wct_control_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_ready, .pos_comp_off,
    .neg_comp_off, .avg_route, .chop_clk, .aug_lead_route, .ref_to_drive_pin,
    .pull_drive, .current_mode, .excite_current_level, .threshold_dac,
    .comparator_enable, .frame_status, .irq
  );
  host_frame_model host_frame_model_i (.aclk, .frame_status, .data_ready);

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // write, then let the registered outputs follow
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
    chk("bresp", elec_pkg::RESP_OKAY, r);
    repeat (3) @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, d, r);
    chk("rresp", elec_pkg::RESP_OKAY, r);
    chk("rdata", e, d);
  endtask : rd

  // cycles that chop_clk stays at level v
  task automatic hold_time(input logic v, output int c);
    c = 0;
    while (chop_clk === v && c < 20000) begin
      @(posedge aclk);
      c++;
    end
  endtask : hold_time

  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pos_comp_off, neg_comp_off} = '0;
    s_axi_wstrb = 4'hF;
    mismatches = 0;
    samples_checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(8'(4 * i), 32'h0);
    axi_rd(8'h2C, d, r);
    chk("unmapped", {30'h0, elec_pkg::RESP_SLVERR}, {d[29:0], r});
    axi_wr(8'h02, 32'hFFFF_FFFF, r);
    chk("misaligned", elec_pkg::RESP_SLVERR, r);
    wr(elec_pkg::ADDR_AVG_SELECT, 32'h1D5);
    chk("select", 32'h157, 32'(avg_route[11:3]));
    for (int i = 0; i < 8; i++) begin
      wr(elec_pkg::ADDR_AVG_CONTROL, 32'(i));
      chk("power", 32'(i), 32'(avg_route.pwr));
    end
    hold_time(1'b1, n);
    hold_time(1'b0, n);
    hold_time(1'b1, n);
    chk("chop", 32'(elec_pkg::CHOP_HALF), 32'(n));
    wr(elec_pkg::ADDR_AVG_CONTROL, 32'h18);
    chk("aug drive chop", 32'h6, {aug_lead_route, ref_to_drive_pin, chop_clk});
    wr(elec_pkg::ADDR_AVG_CONTROL, 32'h0);
    chk("aug drive off", 32'h0, {aug_lead_route, ref_to_drive_pin});
    wr(elec_pkg::ADDR_POS_ENABLES, 32'h85);
    wr(elec_pkg::ADDR_NEG_ENABLES, 32'h03);
    wr(elec_pkg::ADDR_OFF_CONFIG, 32'hB8);
    chk("excite", 32'h6B, {current_mode, excite_current_level, threshold_dac});
    chk("dc pull", 32'h8500_0003, pull_drive);
    wr(elec_pkg::ADDR_SWAP, 32'h01);
    chk("swap", 32'h8401_0102, pull_drive);
    wr(elec_pkg::ADDR_CONFIG_FOUR, 32'h2);
    chk("excite off", 32'h1, {pull_drive, comparator_enable});
    wr(elec_pkg::ADDR_CONFIG_FOUR, 32'h0);
    pos_comp_off <= 8'h06;
    neg_comp_off <= 8'h02;
    repeat (4) @(posedge aclk);
    chk("irq masked", 32'h0, irq);
    wr(elec_pkg::ADDR_IRQ_MASK, 32'h3);
    chk("irq", 32'h1, irq);
    host_frame_model_i.take_frame(fr);
    chk("frame", 32'h0402, fr);
    rd(elec_pkg::ADDR_POS_STATUS, 32'h04);
    rd(elec_pkg::ADDR_IRQ_STATUS, 32'h3);
    rd(elec_pkg::ADDR_IRQ_STATUS, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, irq);
    wr(elec_pkg::ADDR_CONFIG_FOUR, 32'h1);
    host_frame_model_i.take_frame(fr);
    chk("powered down", 32'h0, {comparator_enable, fr});
    wr(elec_pkg::ADDR_CONFIG_FOUR, 32'h0);
    wr(elec_pkg::ADDR_SWAP, 32'h0);
    // half rate toggles each sample, quarter rate every second sample
    for (int k = 1; k <= 2; k++) begin
      wr(elec_pkg::ADDR_OFF_CONFIG, (k == 1) ? 32'hB9 : 32'hBB);
      p0 = pull_drive;
      repeat (k) host_frame_model_i.take_frame(fr);
      chk("ac toggle", 32'h1, 32'(p0 !== pull_drive));
      repeat (k) host_frame_model_i.take_frame(fr);
      chk("ac period", p0, pull_drive);
    end
    stop_test();
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
endmodule : electrode_off_and_wct_control_bench
